/* File: src/run_start_pkg.sv */
package run_start_pkg;

  // Clock period and the machine-cycle figures, each in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int MACHINE_CYCLE_NS = 1600;
  localparam int START_PULSE_NS = 1400;

  // Cycle counts derived from the figures above.
  localparam int MACHINE_CYCLE_CLKS = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
  localparam int START_PULSE_CLKS = START_PULSE_NS / CLK_PERIOD_NS;

  // Synchroniser depth and the number of switch contacts.
  localparam int SYNC_STAGES = 2;
  localparam int CONTACT_COUNT = 2;

  // Bit positions of the two contacts in the contact bundle.
  localparam int CONTACT_NO_POS = 0;
  localparam int CONTACT_NC_POS = 1;

  // Values held after reset.
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_STAGE = 1'b0;
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_RUN_LAMP = 1'b0;
  localparam logic RST_HALT_LAMP = 1'b1;
  localparam logic [CONTACT_COUNT-1:0] RST_CONTACTS = 2'h2;

  // Time states of the machine cycle, T0 first.
  typedef enum logic [2:0] {
    TS_T0, TS_T1, TS_T2, TS_T3, TS_T4, TS_T5, TS_T6, TS_T7
  } time_state_type;

  // Time-state bundle from the timing generator, same clock domain.
  typedef struct packed {
    time_state_type state; // Current time state.
    logic first;           // First clock of the current state.
    logic last;            // Last clock of the current state.
    logic t7s;             // Strobed T7 state is in progress.
  } timing_type;

  // Run state handed to the phase logic.
  typedef struct packed {
    logic early; // Early run latch.
    logic late;  // Late run latch.
  } run_state_type;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import run_start_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [CONTACT_COUNT-1:0] pins_i, // Raw contact levels.
  output logic [CONTACT_COUNT-1:0] pins_o // Synchronised levels.
);

  logic [CONTACT_COUNT-1:0] meta_r;
  logic [CONTACT_COUNT-1:0] hold_r;

  // Two flops per contact; the first is read only by the second.
  genvar g;
  generate
    for (g = 0; g < CONTACT_COUNT; g = g + 1) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_r[g] <= RST_CONTACTS[g];
          hold_r[g] <= RST_CONTACTS[g];
        end else begin
          meta_r[g] <= pins_i[g];
          hold_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign pins_o = hold_r;

endmodule
`default_nettype wire

/* File: src/run_start_ctrl.sv */
// Overview of operation
// - The switch level is held true while the button is pressed, by a set-reset latch on both contacts so bounce is hidden.
// - The switch level drops as soon as the released button's normally-closed contact restores the other latch input.
// - The first sync stage takes the switch level at every T2, so it sets at the first T2 with the level true and clears at the first T2 after it drops.
// - The second sync stage copies the first stage at every T1, so it sets at the next T1 and clears at the first T1 after the first stage clears.
// - The start pulse is first stage set and second stage clear, from T2 to the next T1, 1.4 us wide.
// - The start pulse, gated with the switch level, drives the set inputs of both run latches.
// - With the gated start pulse present the early run latch sets at the end of T5.
// - With the gated start pulse present the late run latch sets at the end of T7S.
// - Both run latches hold set until preset or halt clears them.
// - A machine cycle is 1.6 us of T0 to T7, so at most one start pulse arises per cycle.
// - Both run latch outputs go to the phase logic.
// - The run lamp follows the late run latch and the halt lamp is its inverse.
`timescale 1ns/1ps
`default_nettype none
module run_start_ctrl
  import run_start_pkg::*;
(
  input wire logic CLK_SYS_I, // System clock, 25 MHz.
  input wire logic RST_I, // Asynchronous reset, active high.
  input wire logic RUN_NO_CONTACT_I, // Normally-open contact, high pressed.
  input wire logic RUN_NC_CONTACT_I, // Normally-closed contact, high released.
  input wire timing_type TIMING_I, // Time states from the generator.
  input wire logic PRESET_I, // Preset, clears the run latches.
  input wire logic HALT_I, // Halt, clears the run latches.
  output run_state_type RUN_STATE_O, // Run latches to the phase logic.
  output logic SWITCH_LEVEL_O, // Debounced run switch level.
  output logic START_PULSE_O, // Gated start pulse.
  output logic RUN_LAMP_O, // Run lamp drive, high lit.
  output logic HALT_LAMP_O // Halt lamp drive, high lit.
);

  ////////////////////////////////////////////////////////////////////////
  // Contact synchronisation and debounce latch.

  logic [CONTACT_COUNT-1:0] contacts_raw;
  logic [CONTACT_COUNT-1:0] contacts_sync;
  logic switch_debounce_latch_r;
  logic switch_debounce_latch_nxt;
  wire contact_no = contacts_sync[CONTACT_NO_POS];
  wire contact_nc = contacts_sync[CONTACT_NC_POS];

  assign contacts_raw = {RUN_NC_CONTACT_I, RUN_NO_CONTACT_I};

  pin_sync u_pin_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .pins_i(contacts_raw),
    .pins_o(contacts_sync)
  );

  // A bouncing contact opens both inputs at once, so the latch holds.
  wire latch_set = contact_no & ~contact_nc;
  wire latch_clr = contact_nc & ~contact_no;

  assign switch_debounce_latch_nxt =
    latch_set ? 1'b1 : (latch_clr ? 1'b0 : switch_debounce_latch_r);

  wire run_switch_level = switch_debounce_latch_r;

  ////////////////////////////////////////////////////////////////////////
  // Time-state decode.

  // Stages sample at the first clock of their state, so each acts once.
  wire at_t2 = (TIMING_I.state == TS_T2) & TIMING_I.first;
  wire at_t1 = (TIMING_I.state == TS_T1) & TIMING_I.first;
  wire end_t5 = (TIMING_I.state == TS_T5) & TIMING_I.last;
  wire end_t7s = (TIMING_I.state == TS_T7) & TIMING_I.t7s & TIMING_I.last;

  ////////////////////////////////////////////////////////////////////////
  // Synchronising stages and start pulse.

  logic first_sync_stage_r;
  logic first_sync_stage_nxt;
  logic second_sync_stage_r;
  logic second_sync_stage_nxt;
  logic start_qual;

  assign first_sync_stage_nxt = at_t2 ? run_switch_level : first_sync_stage_r;

  assign second_sync_stage_nxt =
    at_t1 ? first_sync_stage_r : second_sync_stage_r;

  // at most one pulse per machine cycle, since T2 and T1 each come once
  assign start_qual = first_sync_stage_r & ~second_sync_stage_r &
                      run_switch_level;

  ////////////////////////////////////////////////////////////////////////
  // Run latches and lamps.

  logic early_run_latch_r;
  logic early_run_latch_nxt;
  logic late_run_latch_r;
  logic late_run_latch_nxt;
  wire run_clear = PRESET_I | HALT_I;

  // early latch set at end of T5
  // preset or halt clears, and clearing wins over a set
  assign early_run_latch_nxt = run_clear ? 1'b0 :
    ((start_qual & end_t5) ? 1'b1 : early_run_latch_r);

  // late latch set at end of T7S
  assign late_run_latch_nxt = run_clear ? 1'b0 :
    ((start_qual & end_t7s) ? 1'b1 : late_run_latch_r);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      switch_debounce_latch_r <= RST_LATCH;
      first_sync_stage_r <= RST_STAGE;
      second_sync_stage_r <= RST_STAGE;
    end else begin
      switch_debounce_latch_r <= switch_debounce_latch_nxt;
      first_sync_stage_r <= first_sync_stage_nxt;
      second_sync_stage_r <= second_sync_stage_nxt;
    end
  end

  // run latches clear and halt lamp lit after reset
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      early_run_latch_r <= RST_RUN;
      late_run_latch_r <= RST_RUN;
      RUN_LAMP_O <= RST_RUN_LAMP;
      HALT_LAMP_O <= RST_HALT_LAMP;
    end else begin
      early_run_latch_r <= early_run_latch_nxt;
      late_run_latch_r <= late_run_latch_nxt;
      RUN_LAMP_O <= late_run_latch_nxt;
      HALT_LAMP_O <= ~late_run_latch_nxt;
    end
  end

  // Output copies are flops so the panel sees no decode glitches.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      SWITCH_LEVEL_O <= RST_LATCH;
      START_PULSE_O <= RST_STAGE;
    end else begin
      SWITCH_LEVEL_O <= switch_debounce_latch_nxt;
      START_PULSE_O <= first_sync_stage_nxt & ~second_sync_stage_nxt &
                       switch_debounce_latch_nxt;
    end
  end

  // both latches to the phase logic
  assign RUN_STATE_O = '{early: early_run_latch_r, late: late_run_latch_r};

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  // Pulse length counter; only the checks below read it.
  logic [5:0] pulse_len_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_len_r <= 6'h00;
    end else begin
      pulse_len_r <= (first_sync_stage_r & ~second_sync_stage_r) ?
                     pulse_len_r + 6'h01 : 6'h00;
    end
  end

  sequence s_press;
    contact_no & ~contact_nc;
  endsequence

  sequence s_release;
    contact_nc & ~contact_no;
  endsequence

  a_latch_press: assert property (
    s_press |=> run_switch_level)
    else $error("Switch level not set by press.");

  a_latch_release: assert property (
    s_release |=> !run_switch_level)
    else $error("Switch level not cleared by release.");

  a_latch_hold: assert property (
    (!contact_no && !contact_nc) |=> $stable(run_switch_level))
    else $error("Switch level moved during bounce.");

  a_first_stage_t2: assert property (
    !at_t2 |=> $stable(first_sync_stage_r))
    else $error("First stage changed outside T2.");

  a_first_stage_take: assert property (
    at_t2 |=> first_sync_stage_r == $past(run_switch_level))
    else $error("First stage missed the level at T2.");

  a_second_stage_t1: assert property (
    at_t1 |=> second_sync_stage_r == $past(first_sync_stage_r))
    else $error("Second stage missed the copy at T1.");

  a_pulse_width: assert property (
    pulse_len_r <= 6'(START_PULSE_CLKS))
    else $error("Start pulse longer than its width.");

  a_early_set: assert property (
    (start_qual && end_t5 && !run_clear) |=> RUN_STATE_O.early)
    else $error("Early run latch not set at end of T5.");

  a_late_set: assert property (
    (start_qual && end_t7s && !run_clear) |=> RUN_STATE_O.late)
    else $error("Late run latch not set at end of T7S.");

  a_early_only_t5: assert property (
    $rose(early_run_latch_r) |-> $past(start_qual && end_t5))
    else $error("Early run latch set at the wrong time.");

  a_run_clear: assert property (
    run_clear |=> (!early_run_latch_r && !late_run_latch_r))
    else $error("Run latches not cleared by preset or halt.");

  a_run_hold: assert property (
    (late_run_latch_r && !run_clear) |=> late_run_latch_r)
    else $error("Late run latch dropped without a clear.");

  a_lamps: assert property (
    (RUN_LAMP_O == late_run_latch_r) && (HALT_LAMP_O != RUN_LAMP_O))
    else $error("Lamps disagree with the late run latch.");

endmodule
`default_nettype wire

/* File: tb/run_button_model.sv */
`timescale 1ns/1ps
`default_nettype none
module run_button_model (
  input wire logic clk_i, // System clock.
  input wire logic press_i, // Operator holds the button.
  output logic no_o, // Normally-open contact, high closed.
  output logic nc_o // Normally-closed contact, high closed.
);
  logic held_r;
  logic press_s;
  logic [2:0] chatter_r;

  initial begin
    held_r = 1'b0;
    chatter_r = 3'h0;
    no_o = 1'b0;
    nc_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break before make, then the closing contact chatters for a while.
  // bounce on contacts
  // The request is taken at the edge, since the bench moves it just after.
  always @(posedge clk_i) begin
    press_s = press_i;
    #1;
    if (press_s !== held_r) begin
      held_r = press_i;
      chatter_r = 3'h6;
    end else if (chatter_r != 3'h0) begin
      chatter_r = chatter_r - 3'h1;
    end
    no_o = held_r & (chatter_r[0] | (chatter_r == 3'h0));
    nc_o = !held_r & (chatter_r[0] | (chatter_r == 3'h0));
  end
endmodule
`default_nettype wire

/* File: tb/front_panel_run_start_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module front_panel_run_start_control_tb
  import run_start_pkg::*;
;
  localparam int MC = MACHINE_CYCLE_CLKS;
  localparam int STATE_CLKS = MC / 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic press = 1'b0;
  logic halt = 1'b0;
  logic preset = 1'b0;
  logic no_c, nc_c, sw_lvl, pulse, run_lamp, halt_lamp, prev_p, prev_e;
  logic prev_l, lamp_bad;
  timing_type tim, seen_tm, pulse_at, early_at, late_at;
  run_state_type run_st;
  int cnt, fail_count, checked, pulse_cnt, pulse_len;

  run_button_model i_run_button_model (.clk_i(clk), .press_i(press),
    .no_o(no_c), .nc_o(nc_c));
  run_start_ctrl i_run_start_ctrl (.CLK_SYS_I(clk), .RST_I(rst),
    .RUN_NO_CONTACT_I(no_c), .RUN_NC_CONTACT_I(nc_c), .TIMING_I(tim),
    .PRESET_I(preset), .HALT_I(halt), .RUN_STATE_O(run_st),
    .SWITCH_LEVEL_O(sw_lvl), .START_PULSE_O(pulse), .RUN_LAMP_O(run_lamp),
    .HALT_LAMP_O(halt_lamp));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a time-state generator stepping T0 to T7 every cycle.
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  function automatic timing_type tim_of(input int c);
    timing_type t;
    t.state = time_state_type'(3'(c / STATE_CLKS));
    t.first = (c % STATE_CLKS) == 0;
    t.last = (c % STATE_CLKS) == STATE_CLKS - 1;
    t.t7s = t.state == TS_T7;
    return t;
  endfunction

  always @(posedge clk) begin
    #1;
    cnt = (cnt == MC - 1) ? 0 : cnt + 1;
    tim = tim_of(cnt);
  end

  // Records the time state each edge saw when an output rose.
  always @(posedge clk) begin
    seen_tm = tim;
    #1;
    if (pulse === 1'b1) pulse_len++;
    if (pulse === 1'b1 && prev_p !== 1'b1) pulse_cnt++;
    if (pulse === 1'b1 && prev_p !== 1'b1) pulse_at = seen_tm;
    if (run_st.early === 1'b1 && prev_e !== 1'b1) early_at = seen_tm;
    if (run_st.late === 1'b1 && prev_l !== 1'b1) late_at = seen_tm;
    if (run_lamp !== run_st.late || halt_lamp !== !run_st.late) begin
      lamp_bad = 1'b1;
    end
    prev_p = pulse;
    prev_e = run_st.early;
    prev_l = run_st.late;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clear_stats();
    pulse_cnt = 0;
    pulse_len = 0;
    lamp_bad = 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios; each judges its own outcome.
  task automatic test_reset();
    tick(12);
    check(8'({run_st, sw_lvl, pulse, run_lamp, halt_lamp}), 8'h01);
    rst = 1'b0;
    $display("test_reset done");
  endtask

  // Release just after the pulse starts: the gate cuts it before T5.
  task automatic test_short_press();
    int i;
    clear_stats();
    press = 1'b1;
    for (i = 0; i < 3 * MC && pulse !== 1'b1; i++) tick(1);
    if (pulse !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    press = 1'b0;
    tick(2 * MC);
    check(8'(pulse_len < 15), 8'h01);
    check(8'(run_st), 8'h00);
    check(8'(sw_lvl), 8'h00);
    $display("test_short_press done");
  endtask

  task automatic test_held_press();
    clear_stats();
    press = 1'b1;
    tick(3 * MC);
    check(8'(sw_lvl), 8'h01);
    check(8'(pulse_cnt), 8'h01);
    check(8'(pulse_len), 8'(START_PULSE_CLKS));
    check(8'({pulse_at.state, pulse_at.first}), 8'({TS_T2, 1'b1}));
    check(8'({early_at.state, early_at.last}), 8'({TS_T5, 1'b1}));
    check(8'({late_at.state, late_at.last, late_at.t7s}), 8'h1f);
    check(8'(run_st), 8'h03);
    check(8'(lamp_bad), 8'h00);
    press = 1'b0;
    tick(2 * MC);
    check(8'(sw_lvl), 8'h00);
    check(8'(pulse_cnt), 8'h01);
    check(8'({run_st, run_lamp, halt_lamp}), 8'h0e);
    $display("test_held_press done");
  endtask

  // Halt then preset, each after a fresh start.
  task automatic test_clear();
    int k;
    for (k = 0; k < 2; k++) begin
      press = 1'b1;
      tick(2 * MC);
      press = 1'b0;
      tick(MC);
      check(8'(run_st), 8'h03);
      halt = (k == 0);
      preset = (k == 1);
      tick(1);
      halt = 1'b0;
      preset = 1'b0;
      check(8'({run_st, run_lamp, halt_lamp}), 8'h01);
      tick(MC);
      check(8'(run_st), 8'h00);
    end
    $display("test_clear done");
  endtask

  // Reset in mid-run with both run latches set, then a quiet stretch.
  task automatic test_mid_reset();
    press = 1'b1;
    tick(2 * MC);
    press = 1'b0;
    tick(MC);
    check(8'(run_st), 8'h03);
    rst = 1'b1;
    tick(2);
    check(8'({run_st, sw_lvl, pulse, run_lamp, halt_lamp}), 8'h01);
    rst = 1'b0;
    tick(2 * MC);
    check(8'({run_st, sw_lvl, pulse, run_lamp, halt_lamp}), 8'h01);
    $display("test_mid_reset done");
  endtask

  initial begin
    cnt = 0;
    tim = tim_of(0);
    fail_count = 0;
    checked = 0;
    clear_stats();
    test_reset();
    test_short_press();
    test_held_press();
    test_clear();
    test_mid_reset();
    finish_test();
  end
endmodule
`default_nettype wire
